// File: verilog/mfa_defs.svh
// constants for the fetch sequencer and data addressing front end
`ifndef MFA_DEFS_SVH
`define MFA_DEFS_SVH

// ************************************************************
// widths and depths
// ************************************************************
`define MFA_PC_W 10
`define MFA_IR_W 14
`define MFA_DATA_W 8
`define MFA_FADDR_W 7
`define MFA_WOP_AW 5
`define MFA_SFR_AW 5
`define MFA_RAM_AW 5
`define MFA_RAM_DEPTH 32
`define MFA_STK_DEPTH 5
`define MFA_STK_PW 3
`define MFA_STK_LAST 3'h4
`define MFA_STK_ZERO 3'h0
`define MFA_STK_ONE 3'h1

// ************************************************************
// vectors and reset values
// ************************************************************
`define MFA_RST_VEC 10'h000
`define MFA_INT_VEC 10'h001
`define MFA_PC_ONE 10'h001
`define MFA_PTR_RST 8'h00
`define MFA_ZERO_BYTE 8'h00
`define MFA_BIT_ONE 8'h01
`define MFA_IR_RST 14'h0000

// ************************************************************
// data plane map
// ************************************************************
`define MFA_IND_ADDR 7'h00
`define MFA_PCL_ADDR 7'h02
`define MFA_PTR_ADDR 7'h04
`define MFA_SFR_LAST 7'h1F
`define MFA_RAM_FIRST 7'h20
`define MFA_RAM_LAST 7'h3F
`define MFA_WOP_LAST 5'h12

// ************************************************************
// instruction fields and group codes
// ************************************************************
`define MFA_FLD_GRP 13:12
`define MFA_FLD_SUB 11:8
`define MFA_FLD_BOP 11:10
`define MFA_FLD_CALL 11
`define MFA_FLD_BIT 8:6
`define MFA_FLD_DIR 7
`define MFA_FLD_WOPSEL 7:6
`define MFA_FLD_F 6:0
`define MFA_FLD_BF 5:0
`define MFA_FLD_WOP 4:0
`define MFA_FLD_LIT 7:0
`define MFA_FLD_JMP 9:0
`define MFA_FLD_PCHI 9:8
`define MFA_FLD_PCLO 7:0
`define MFA_GRP_MISC 2'h0
`define MFA_GRP_BIT 2'h1
`define MFA_GRP_JMP 2'h2
`define MFA_GRP_LIT 2'h3
`define MFA_SUB_MISC 4'h0
`define MFA_SUB_ONE 6'h01
`define MFA_WOPSEL 2'h1
`define MFA_MISC_LAST 8'h05
`define MFA_LIT_LAST 4'h6
`define MFA_F_PAD 1'h0

`endif

// File: verilog/mfa_pkg.sv
// types and instruction decoder for the fetch sequencer
`include "mfa_defs.svh"
package mfa_pkg;

    typedef enum logic {
        MFA_PH_ONE = 1'b0,
        MFA_PH_TWO = 1'b1
    } mfa_phase_t;

    // order matters: decoder builds codes by offset from group bases
    typedef enum logic [5:0] {
        OP_NOP, OP_RET, OP_RETI, OP_SLEEP, OP_CLRWDT, OP_CLRW, OP_MOV_WOP,
        OP_MOVWF, OP_CLRF, OP_SUBWF, OP_DECF, OP_IORWF, OP_ANDWF, OP_XORWF,
        OP_ADDWF, OP_MOVF, OP_COMF, OP_INCF, OP_DECFSZ, OP_RRF, OP_RLF,
        OP_SWAPF, OP_INCFSZ,
        OP_BCF, OP_BSF, OP_BTFSC, OP_BTFSS,
        OP_GOTO, OP_CALL,
        OP_MOVLW, OP_RETLW, OP_ADDLW, OP_SUBLW, OP_ANDLW, OP_IORLW, OP_XORLW,
        OP_BAD
    } mfa_op_t;

    function automatic mfa_op_t mfa_decode(input logic [`MFA_IR_W-1:0] ir);
        mfa_op_t op;
        op = OP_BAD;
        case (ir[`MFA_FLD_GRP])
            `MFA_GRP_MISC: begin
                if (ir[`MFA_FLD_SUB] != `MFA_SUB_MISC)
                    op = mfa_op_t'(6'(OP_MOVWF) + 6'(ir[`MFA_FLD_SUB]) - `MFA_SUB_ONE);
                else if (ir[`MFA_FLD_WOPSEL] == `MFA_WOPSEL)
                    op = OP_MOV_WOP;
                else if (ir[`MFA_FLD_LIT] <= `MFA_MISC_LAST)
                    op = mfa_op_t'(6'(ir[`MFA_FLD_LIT]));
            end
            `MFA_GRP_BIT: op = mfa_op_t'(6'(OP_BCF) + 6'(ir[`MFA_FLD_BOP]));
            `MFA_GRP_JMP: op = ir[`MFA_FLD_CALL] ? OP_CALL : OP_GOTO;
            `MFA_GRP_LIT: begin
                if (ir[`MFA_FLD_SUB] <= `MFA_LIT_LAST)
                    op = mfa_op_t'(6'(OP_MOVLW) + 6'(ir[`MFA_FLD_SUB]));
            end
            default: op = OP_BAD;
        endcase
        return op;
    endfunction

endpackage

// File: verilog/mfa_stack_if.sv
// return-address stack link between core and stack
`timescale 1ns/10ps
`include "mfa_defs.svh"
interface mfa_stack_if;
    logic push;
    logic pop;
    logic [`MFA_PC_W-1:0] push_addr;
    logic [`MFA_PC_W-1:0] top_addr;
    modport core (output push, output pop, output push_addr, input top_addr);
    modport stack (input push, input pop, input push_addr, output top_addr);
endinterface

// File: verilog/mfa_ret_stack.sv
// circular return-address stack
`timescale 1ns/10ps
`include "mfa_defs.svh"
module mfa_ret_stack import mfa_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    mfa_stack_if.stack sif
);
    logic [`MFA_PC_W-1:0] mem [0:`MFA_STK_DEPTH-1];
    logic [`MFA_STK_PW-1:0] sp_reg;
    logic [`MFA_STK_PW-1:0] sp_next;
    wire [`MFA_STK_PW-1:0] sp_inc;
    wire [`MFA_STK_PW-1:0] sp_dec;

    // overflow wraps onto the oldest entry, as a fixed-depth stack would
    assign sp_inc = (sp_reg == `MFA_STK_LAST) ? `MFA_STK_ZERO : sp_reg + `MFA_STK_ONE;
    assign sp_dec = (sp_reg == `MFA_STK_ZERO) ? `MFA_STK_LAST : sp_reg - `MFA_STK_ONE;
    assign sp_next = sif.push ? sp_inc : (sif.pop ? sp_dec : sp_reg);
    assign sif.top_addr = mem[sp_dec];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_reg <= `MFA_STK_ZERO;
        end else begin
            sp_reg <= sp_next;
        end
    end

    always_ff @(posedge clk) begin
        if (sif.push) begin
            mem[sp_reg] <= sif.push_addr;
        end
    end
endmodule

// File: verilog/mfa_core.sv
// two-phase fetch sequencer with data plane addressing
`timescale 1ns/10ps
`include "mfa_defs.svh"
module mfa_core import mfa_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    output logic [`MFA_PC_W-1:0] prog_addr,
    input wire logic [`MFA_IR_W-1:0] prog_word,
    output logic phase_one,
    output logic phase_two,
    output logic exec_valid,
    output mfa_op_t exec_op,
    output logic [`MFA_DATA_W-1:0] exec_literal,
    output logic exec_dest_f,
    output logic [`MFA_DATA_W-1:0] file_rdata,
    input wire logic [`MFA_DATA_W-1:0] w_value,
    input wire logic [`MFA_DATA_W-1:0] alu_result,
    input wire logic alu_skip,
    input wire logic int_req,
    output logic int_ack,
    output logic [`MFA_SFR_AW-1:0] sfr_addr,
    output logic sfr_we,
    output logic [`MFA_DATA_W-1:0] sfr_wdata,
    input wire logic [`MFA_DATA_W-1:0] sfr_rdata,
    output logic wop_we,
    output logic [`MFA_WOP_AW-1:0] wop_addr,
    output logic [`MFA_DATA_W-1:0] wop_data
);

    // ************************************************************
    // reset release and phase sequencer
    // ************************************************************
    logic rst_s1_reg;
    logic rst_s2_reg;
    wire rst_core_n;
    mfa_phase_t phase_reg;
    mfa_phase_t phase_next;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rst_core_n = rst_s2_reg;

    always_comb begin
        case (phase_reg)
            MFA_PH_ONE: phase_next = MFA_PH_TWO;
            MFA_PH_TWO: phase_next = MFA_PH_ONE;
            default: phase_next = MFA_PH_ONE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            phase_reg <= MFA_PH_ONE;
        end else if (clk_en) begin
            phase_reg <= phase_next;
        end
    end

    wire ph1_edge = clk_en && (phase_reg == MFA_PH_ONE);
    wire ph2_edge = clk_en && (phase_reg == MFA_PH_TWO);
    assign phase_one = (phase_reg == MFA_PH_ONE);
    assign phase_two = (phase_reg == MFA_PH_TWO);

    // ************************************************************
    // pipeline state
    // ************************************************************
    logic [`MFA_PC_W-1:0] pc_reg;
    logic boot_reg;
    logic [`MFA_IR_W-1:0] ir_reg;
    logic ir_valid_reg;
    logic pend_br_reg;
    logic [`MFA_PC_W-1:0] pend_tgt_reg;
    logic [`MFA_DATA_W-1:0] ptr_reg;
    logic int_ack_reg;
    logic wop_we_reg;
    logic [`MFA_WOP_AW-1:0] wop_addr_reg;
    logic [`MFA_DATA_W-1:0] wop_data_reg;
    logic [`MFA_DATA_W-1:0] ram [0:`MFA_RAM_DEPTH-1];
    mfa_stack_if sif ();

    // ************************************************************
    // decode and file plane addressing
    // ************************************************************
    wire mfa_op_t op = mfa_decode(ir_reg);
    wire live = ir_valid_reg;
    wire grp_bit = (ir_reg[`MFA_FLD_GRP] == `MFA_GRP_BIT);
    // bit forms carry only a 6-bit address, so the upper half is unreachable
    wire [`MFA_FADDR_W-1:0] dir_addr = grp_bit ? {`MFA_F_PAD, ir_reg[`MFA_FLD_BF]}
                                               : ir_reg[`MFA_FLD_F];
    wire is_ind = (dir_addr == `MFA_IND_ADDR);
    wire [`MFA_FADDR_W-1:0] eff_addr = is_ind ? ptr_reg[`MFA_FADDR_W-1:0]
                                              : dir_addr;
    // pointer aimed at the port itself finds nothing behind it
    wire eff_null = (eff_addr == `MFA_IND_ADDR);
    wire in_sfr = !eff_null && (eff_addr <= `MFA_SFR_LAST);
    wire in_ram = (eff_addr >= `MFA_RAM_FIRST) && (eff_addr <= `MFA_RAM_LAST);
    wire hit_pcl = in_sfr && (eff_addr == `MFA_PCL_ADDR);
    wire hit_ptr = in_sfr && (eff_addr == `MFA_PTR_ADDR);
    wire ext_sfr = in_sfr && !hit_pcl && !hit_ptr;
    wire [`MFA_RAM_AW-1:0] ram_idx = eff_addr[`MFA_RAM_AW-1:0];
    wire [`MFA_DATA_W-1:0] rdata = hit_pcl ? pc_reg[`MFA_FLD_PCLO] :
                                   hit_ptr ? ptr_reg :
                                   ext_sfr ? sfr_rdata :
                                   in_ram ? ram[ram_idx] :
                                   `MFA_ZERO_BYTE;

    // ************************************************************
    // execute: writes, bit logic, branch resolution
    // ************************************************************
    wire [`MFA_DATA_W-1:0] bit_mask = `MFA_BIT_ONE << ir_reg[`MFA_FLD_BIT];
    wire bit_val = |(rdata & bit_mask);
    wire byte_op = (op >= OP_MOVWF) && (op <= OP_INCFSZ);
    wire f_write = live && ((op == OP_MOVWF) || (op == OP_CLRF) || (op == OP_BCF)
                   || (op == OP_BSF) || (byte_op && ir_reg[`MFA_FLD_DIR]));
    wire [`MFA_DATA_W-1:0] f_wdata = (op == OP_MOVWF) ? w_value :
                                     (op == OP_BSF) ? (rdata | bit_mask) :
                                     (op == OP_BCF) ? (rdata & ~bit_mask) :
                                     alu_result;
    wire commit_wr = ph2_edge && f_write;
    wire pcl_wr = f_write && hit_pcl;
    wire is_ret = (op == OP_RET) || (op == OP_RETI) || (op == OP_RETLW);
    wire is_jmp = (op == OP_GOTO) || (op == OP_CALL);
    wire jump_now = live && (is_jmp || is_ret || pcl_wr);
    wire skip_now = live && (((op == OP_BTFSC) && !bit_val)
                   || ((op == OP_BTFSS) && bit_val)
                   || (((op == OP_INCFSZ) || (op == OP_DECFSZ)) && alu_skip));
    // interrupt waits out a branch or skip so the pushed address is exact
    wire int_take = int_req && !jump_now && !skip_now;
    wire [`MFA_PC_W-1:0] br_tgt = int_take ? `MFA_INT_VEC :
                                  is_ret ? sif.top_addr :
                                  pcl_wr ? {pc_reg[`MFA_FLD_PCHI], f_wdata} :
                                  ir_reg[`MFA_FLD_JMP];
    wire wop_hit = live && (op == OP_MOV_WOP)
                   && (ir_reg[`MFA_FLD_WOP] <= `MFA_WOP_LAST);

    assign sif.push = ph2_edge && ((live && (op == OP_CALL)) || int_take);
    assign sif.pop = ph2_edge && live && is_ret;
    assign sif.push_addr = pc_reg;

    mfa_ret_stack u_stack (
        .clk(clk),
        .rst_n(rst_core_n),
        .sif(sif)
    );

    // ************************************************************
    // phase one: counter update
    // ************************************************************
    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            pc_reg <= `MFA_RST_VEC;
            boot_reg <= 1'b1;
        end else if (ph1_edge) begin
            boot_reg <= 1'b0;
            if (pend_br_reg) begin
                pc_reg <= pend_tgt_reg;
            end else if (!boot_reg) begin
                pc_reg <= pc_reg + `MFA_PC_ONE;
            end
        end
    end

    // ************************************************************
    // phase two: fetch latch, flush and commit
    // ************************************************************
    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            ir_reg <= `MFA_IR_RST;
            ir_valid_reg <= 1'b0;
            pend_br_reg <= 1'b0;
            pend_tgt_reg <= `MFA_RST_VEC;
        end else if (ph2_edge) begin
            ir_reg <= prog_word;
            ir_valid_reg <= !(jump_now || skip_now || int_take);
            pend_br_reg <= jump_now || int_take;
            pend_tgt_reg <= br_tgt;
        end else if (ph1_edge) begin
            pend_br_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            ptr_reg <= `MFA_PTR_RST;
        end else if (commit_wr && hit_ptr) begin
            ptr_reg <= f_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (commit_wr && in_ram) begin
            ram[ram_idx] <= f_wdata;
        end
    end

    // strobes raised at commit stand through the following phase one
    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            int_ack_reg <= 1'b0;
            wop_we_reg <= 1'b0;
            wop_addr_reg <= {`MFA_WOP_AW{1'b0}};
            wop_data_reg <= `MFA_ZERO_BYTE;
        end else if (ph2_edge) begin
            int_ack_reg <= int_take;
            wop_we_reg <= wop_hit;
            wop_addr_reg <= ir_reg[`MFA_FLD_WOP];
            wop_data_reg <= w_value;
        end else if (ph1_edge) begin
            int_ack_reg <= 1'b0;
            wop_we_reg <= 1'b0;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign prog_addr = pc_reg;
    assign exec_valid = ir_valid_reg;
    assign exec_op = op;
    assign exec_literal = ir_reg[`MFA_FLD_LIT];
    assign exec_dest_f = ir_reg[`MFA_FLD_DIR];
    // write-only plane has no read path into this mux
    assign file_rdata = rdata;
    assign sfr_addr = eff_addr[`MFA_SFR_AW-1:0];
    assign sfr_we = commit_wr && ext_sfr;
    assign sfr_wdata = f_wdata;
    assign int_ack = int_ack_reg;
    assign wop_we = wop_we_reg;
    assign wop_addr = wop_addr_reg;
    assign wop_data = wop_data_reg;

endmodule

// File: verif/mfa_core_assertions.sv
// port-level properties of the fetch sequencer
`timescale 1ns/10ps
`include "mfa_defs.svh"
module mfa_core_assertions import mfa_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [`MFA_PC_W-1:0] prog_addr,
    input wire logic phase_one,
    input wire logic phase_two,
    input wire logic exec_valid,
    input wire mfa_op_t exec_op,
    input wire logic int_req,
    input wire logic int_ack,
    input wire logic [`MFA_SFR_AW-1:0] sfr_addr,
    input wire logic sfr_we,
    input wire logic wop_we,
    input wire logic [`MFA_WOP_AW-1:0] wop_addr
);
    // ************************************
    // reset follower
    // ************************************
    // one edge beyond the design's own sync, so $past never sees reset values
    logic [2:0] live_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            live_reg <= 3'h0;
        else
            live_reg <= {live_reg[1:0], 1'b1};
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n || !live_reg[2]);
    // ************************************
    // properties
    // ************************************
    sequence s_branch_commit;
        exec_valid && phase_two && clk_en &&
            (exec_op == OP_GOTO || exec_op == OP_CALL || exec_op == OP_RET);
    endsequence
    sequence s_flushed_slot;
        !exec_valid [*2];
    endsequence
    a_phase_alt: assert property (
        clk_en |=> phase_one != $past(phase_one) && phase_two == !phase_one)
        else $error("phase did not alternate");
    a_addr_hold: assert property (
        $changed(prog_addr) |=> $stable(prog_addr))
        else $error("fetch address changed twice in one cycle");
    a_branch_flush: assert property (
        s_branch_commit |=> s_flushed_slot)
        else $error("slot after branch not flushed");
    a_ack_cause: assert property (
        int_ack |-> $past(int_req) && $past(phase_two) && !exec_valid)
        else $error("ack without request at phase two");
    a_ack_vector: assert property (
        $rose(int_ack) |-> ##[0:4] prog_addr == `MFA_INT_VEC)
        else $error("interrupt vector not fetched");
    a_wop_once: assert property (
        wop_we |=> !wop_we)
        else $error("write-only strobe longer than one clock");
    a_wop_cause: assert property (
        wop_we |-> $past(phase_two) && $past(exec_valid) && $past(exec_op) == OP_MOV_WOP)
        else $error("write-only strobe without its move");
    a_wop_range: assert property (
        wop_we |-> wop_addr <= `MFA_WOP_LAST)
        else $error("write-only address out of range");
    a_sfr_gate: assert property (
        sfr_we |-> phase_two && clk_en && exec_valid && sfr_addr != 5'h00
            && sfr_addr != 5'h02 && sfr_addr != 5'h04)
        else $error("register write outside its slot");
endmodule

// File: verif/test_mfa_core.sv
// self-checking bench for the fetch sequencer
`timescale 1ns/10ps
`include "mfa_defs.svh"
`define CHK(name, exp, got) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
    $display("ERROR %s expected %0h seen %0h", name, exp, got); end end
module test_mfa_core import mfa_pkg::*;;
    logic clk, rst_n, clk_en, alu_skip, int_req;
    logic [`MFA_DATA_W-1:0] w_value, alu_result, sfr_rdata;
    logic [`MFA_IR_W-1:0] rom [0:1023];
    wire [`MFA_IR_W-1:0] prog_word;
    logic [`MFA_PC_W-1:0] prog_addr, x_pc;
    logic phase_one, phase_two, exec_valid, exec_dest_f, int_ack, sfr_we, wop_we;
    mfa_op_t exec_op, x_op;
    logic [`MFA_DATA_W-1:0] exec_literal, file_rdata, sfr_wdata, wop_data, x_lit, x_rd;
    logic [`MFA_SFR_AW-1:0] sfr_addr;
    logic [`MFA_WOP_AW-1:0] wop_addr;
    logic [12:0] wop_log [$];
    logic [12:0] sfr_log [$];
    int err_count, cmp_count, x_cyc;
    // rom answers combinationally, like the outside program store
    assign prog_word = rom[prog_addr];
    mfa_core u_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .prog_addr(prog_addr),
        .prog_word(prog_word), .phase_one(phase_one), .phase_two(phase_two),
        .exec_valid(exec_valid), .exec_op(exec_op), .exec_literal(exec_literal),
        .exec_dest_f(exec_dest_f), .file_rdata(file_rdata), .w_value(w_value),
        .alu_result(alu_result), .alu_skip(alu_skip), .int_req(int_req), .int_ack(int_ack),
        .sfr_addr(sfr_addr), .sfr_we(sfr_we), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .wop_we(wop_we), .wop_addr(wop_addr), .wop_data(wop_data));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (wop_we === 1'b1)
            wop_log.push_back({wop_addr, wop_data});
        if (sfr_we === 1'b1)
            sfr_log.push_back({sfr_addr, sfr_wdata});
    end
    // ************************************
    // helpers
    // ************************************
    task automatic fill();
        foreach (rom[i]) rom[i] = 14'h0000;
    endtask
    task automatic boot(input logic [`MFA_DATA_W-1:0] w);
        @(posedge clk);
        rst_n <= 1'b0;
        w_value <= w;
        repeat (12) @(posedge clk);
        `CHK("reset pc", 10'h000, prog_addr)
        `CHK("reset phase", 1'b1, phase_one)
        rst_n <= 1'b1;
        wop_log.delete();
        sfr_log.delete();
    endtask
    // next live instruction, sampled in its phase-two clock
    task automatic next_exec();
        x_cyc = 0;
        do begin
            @(negedge clk);
            if (phase_two === 1'b1)
                x_cyc++;
        end while (!(phase_two === 1'b1 && exec_valid === 1'b1) && x_cyc < 40);
        x_op = exec_op;
        x_lit = exec_literal;
        x_rd = file_rdata;
        x_pc = prog_addr;
    endtask
    // ************************************
    // scenarios
    // ************************************
    task automatic t_fetch();
        fill();
        rom[0] = 14'h305A;
        rom[1] = 14'h3011;
        boot(8'h00);
        next_exec();
        `CHK("first op", OP_MOVLW, x_op)
        `CHK("first literal", 8'h5A, x_lit)
        `CHK("overlapped fetch", 10'h001, x_pc)
        @(posedge clk);
        clk_en <= 1'b0;
        repeat (6) @(posedge clk);
        clk_en <= 1'b1;
        next_exec();
        `CHK("after freeze", 8'h11, x_lit)
        next_exec();
        `CHK("one per cycle", 1, x_cyc)
    endtask
    task automatic t_branch();
        fill();
        rom[0] = 14'h23FE;
        rom[10'h3FE] = 14'h0182;
        rom[10'h3FF] = 14'h3011;
        rom[10'h340] = 14'h3022;
        boot(8'h40);
        next_exec();
        `CHK("jump op", OP_GOTO, x_op)
        next_exec();
        `CHK("jump cost", 2, x_cyc)
        `CHK("jump pc", 10'h3FF, x_pc)
        next_exec();
        `CHK("low write cost", 2, x_cyc)
        `CHK("low write lit", 8'h22, x_lit)
        `CHK("low write pc", 10'h341, x_pc)
    endtask
    task automatic t_call();
        mfa_op_t exp_op [5];
        exp_op = '{OP_CALL, OP_CALL, OP_RET, OP_RET, OP_MOVLW};
        fill();
        rom[0] = 14'h2955;
        rom[1] = 14'h3033;
        rom[10'h155] = 14'h2AAA;
        rom[10'h156] = 14'h0001;
        rom[10'h2AA] = 14'h0001;
        boot(8'h00);
        for (int i = 0; i < 5; i++) begin
            next_exec();
            `CHK("nest op", exp_op[i], x_op)
        end
        `CHK("return lit", 8'h33, x_lit)
    endtask
    task automatic t_wop();
        fill();
        rom[0] = 14'h0052;
        rom[1] = 14'h0053;
        rom[2] = 14'h0040;
        boot(8'hA5);
        repeat (4) next_exec();
        `CHK("wop count", 2, wop_log.size())
        `CHK("wop top", {5'h12, 8'hA5}, wop_log[0])
        `CHK("wop zero", {5'h00, 8'hA5}, wop_log[1])
    endtask
    task automatic t_file();
        logic [`MFA_IR_W-1:0] prog [13];
        prog = '{14'h0184, 14'h01A5, 14'h1465, 14'h0900, 14'h01C5, 14'h0945,
            14'h0190, 14'h0910, 14'h01BF, 14'h093F, 14'h1C65, 14'h3099, 14'h3055};
        fill();
        foreach (prog[i]) rom[i] = prog[i];
        boot(8'h25);
        repeat (4) next_exec();
        `CHK("indirect bit", 8'h27, x_rd)
        `CHK("dest bit", 1'b0, exec_dest_f)
        repeat (2) next_exec();
        `CHK("unmapped", 8'h00, x_rd)
        repeat (2) next_exec();
        `CHK("sfr read", 8'h6E, x_rd)
        `CHK("sfr write", {5'h10, 8'h25}, sfr_log[0])
        repeat (2) next_exec();
        `CHK("ram top", 8'h25, x_rd)
        next_exec();
        `CHK("bit test op", OP_BTFSS, x_op)
        next_exec();
        `CHK("skip cost", 2, x_cyc)
        `CHK("skip lit", 8'h55, x_lit)
    endtask
    task automatic t_int();
        fill();
        rom[0] = 14'h2010;
        rom[1] = 14'h3077;
        rom[2] = 14'h0002;
        rom[10'h010] = 14'h3044;
        rom[10'h011] = 14'h2010;
        boot(8'h00);
        repeat (3) next_exec();
        @(posedge clk);
        int_req <= 1'b1;
        repeat (20) begin
            @(negedge clk);
            if (int_ack === 1'b1)
                break;
        end
        `CHK("int ack", 1'b1, int_ack)
        @(posedge clk);
        int_req <= 1'b0;
        next_exec();
        `CHK("vector lit", 8'h77, x_lit)
        next_exec();
        `CHK("int return op", OP_RETI, x_op)
        next_exec();
        `CHK("resumed", 8'h44, x_lit)
        `CHK("resumed pc", 10'h011, x_pc)
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        alu_skip = 1'b0;
        int_req = 1'b0;
        w_value = 8'h00;
        alu_result = 8'h00;
        sfr_rdata = 8'h6E;
        t_fetch();
        t_branch();
        t_call();
        t_wop();
        t_file();
        t_int();
        summarize();
    end
    // whole run is well under two thousand clocks
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        summarize();
    end
endmodule
bind mfa_core mfa_core_assertions u_chk (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .prog_addr(prog_addr), .phase_one(phase_one), .phase_two(phase_two),
    .exec_valid(exec_valid), .exec_op(exec_op), .int_req(int_req), .int_ack(int_ack),
    .sfr_addr(sfr_addr), .sfr_we(sfr_we), .wop_we(wop_we), .wop_addr(wop_addr));
